// ==== include/burst_sram_defines.vh ====
`ifndef BURST_SRAM_DEFINES_VH
`define BURST_SRAM_DEFINES_VH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define ADDR_W_DEF      20
`define WORD_W_DEF      18
`define BURST_OFS0      1'b0
`define BURST_OFS1      1'b1

// ----------------------------------------
// byte write select lanes
// ----------------------------------------
`define BWS_LO          0
`define BWS_HI          1

// ----------------------------------------
// timing
// ----------------------------------------
`define SYS_CLK_MHZ     250
`define DLL_STOP_NS     30
`define DLL_LOCK_CYC    1024
`define IMP_UPDATE_CYC  1024
`define STRAP_WAIT_CYC  3

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_WORD        18'h00000
`define RST_SINGLE_MODE 1'b0

`endif

// ==== src/pin_sync2.v ====
`timescale 1ns/100ps

// two flop synchroniser for a bundle of pins
module pin_sync2 #(
	parameter WIDTH = 1
)(
	input  wire             clk_sys,
	input  wire             rstn,
	input  wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] pin_sync
);

	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	// first stage feeds only the second stage
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_r <= {WIDTH{1'b0}};
			sync_r <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	assign pin_sync = sync_r;

endmodule

// ==== src/ddr_separate_io_burst_sram_port.v ====
// Function
// R1: accesses start only on positive input clock rise
// R2: write words captured on both input clock rises
// R3: controls sampled only on positive input rise
// R4: read data launched on output clock rises
// R5: two word bursts, two internal arrays
// R6: load low, read high starts read
// R7: word0 on negative, word1 on positive output
// R8: back to back reads stream every edge
// R9: finish reads, then tristate after positive rise
// R10: load low, read low starts write
// R11: write words on next positive, negative rise
// R12: back to back writes stream every edge
// R13: deselected writes finish, inputs then ignored
// R14: byte selects sampled with each word
// R15: deasserted byte select keeps stored byte
// R16: single clock strap held from power on
// R17: single mode uses input clocks for outputs
// R18: completed write posted, committed next write
// R19: depth expansion needs one load per bank
// R20: impedance update every 1024 clock cycles
// R21: echo clocks follow output or input clocks
// R22: dll locks after 1024 stable cycles
// R23: dll resets when clock stalls 30 ns
// R24: dll disable pin low turns dll off
// R25: powers up deselected, outputs high impedance
// R26: word0 offset zero, word1 offset one
// R27: both selects high writes nothing
// R28: reads hitting posted write return posted data
`timescale 1ns/100ps
`include "burst_sram_defines.vh"

module ddr_separate_io_burst_sram_port #(
	parameter ADDR_W       = `ADDR_W_DEF,
	parameter WORD_W       = `WORD_W_DEF,
	parameter DLL_LOCK_CYC = `DLL_LOCK_CYC,
	parameter IMP_CYC      = `IMP_UPDATE_CYC,
	parameter DLL_STOP_CYC = (`DLL_STOP_NS * `SYS_CLK_MHZ + 999) / 1000
)(
	input  wire              clk_sys,
	input  wire              rstn,
	input  wire              k_clk,
	input  wire              k_n_clk,
	input  wire              c_clk,
	input  wire              c_n_clk,
	input  wire              load_n,
	input  wire              rw_read,
	input  wire [1:0]        byte_write_sel_n,
	input  wire              dll_disable_n,
	input  wire [ADDR_W-1:0] addr,
	input  wire [WORD_W-1:0] wdata,
	output reg  [WORD_W-1:0] rdata,
	output reg               rdata_oe,
	output reg               pos_echo_clk,
	output reg               neg_echo_clk,
	output reg               dll_locked,
	output reg               impedance_update
);

	localparam LO_W  = WORD_W / 2;
	localparam SW    = 9 + ADDR_W + WORD_W;
	localparam DEPTH = 1 << ADDR_W;

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// byte merge, be active high per lane
	function [WORD_W-1:0] merge_bytes;
		input [WORD_W-1:0] old_w;
		input [WORD_W-1:0] new_w;
		input [1:0]        be;
		begin
			merge_bytes = old_w;
			if (be[`BWS_LO])
				merge_bytes[LO_W-1:0] = new_w[LO_W-1:0];
			if (be[`BWS_HI])
				merge_bytes[WORD_W-1:LO_W] = new_w[WORD_W-1:LO_W];
		end
	endfunction

	// ----------------------------------------
	// pin synchronisation and edge detection
	// ----------------------------------------
	wire [SW-1:0]     pins_s;
	wire              k_s;
	wire              kn_s;
	wire              c_s;
	wire              cn_s;
	wire              load_n_s;
	wire              rw_read_s;
	wire [1:0]        bws_n_s;
	wire              dll_dis_n_s;
	wire [ADDR_W-1:0] addr_s;
	wire [WORD_W-1:0] wdata_s;

	pin_sync2 #(
		.WIDTH (SW)
	) u_sync (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.pin_in   ({k_clk, k_n_clk, c_clk, c_n_clk, load_n, rw_read,
		            byte_write_sel_n, dll_disable_n, addr, wdata}),
		.pin_sync (pins_s)
	);

	assign {k_s, kn_s, c_s, cn_s, load_n_s, rw_read_s,
	        bws_n_s, dll_dis_n_s, addr_s, wdata_s} = pins_s;

	reg  [3:0] clk_d_r;
	reg        single_mode_r;
	reg        strap_done_r;
	reg  [1:0] strap_cnt_r;

	// previous sampled clock levels
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			clk_d_r <= 4'h0;
		else
			clk_d_r <= {k_s, kn_s, c_s, cn_s};
	end

	wire k_rise   = strap_done_r & k_s & ~clk_d_r[3];
	wire kn_rise  = strap_done_r & kn_s & ~clk_d_r[2];
	wire c_rise   = strap_done_r & c_s & ~clk_d_r[1];
	wire cn_rise  = strap_done_r & cn_s & ~clk_d_r[0];
	// zero skew stand in for output clocks in single mode
	wire opos_rise = single_mode_r ? k_rise : c_rise;   // R4 R17
	wire oneg_rise = single_mode_r ? kn_rise : cn_rise; // R4 R17

	// ----------------------------------------
	// single clock strap
	// ----------------------------------------

	// caught after release, once the synchroniser has filled
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			strap_cnt_r   <= 2'h0;
			strap_done_r  <= 1'b0;
			single_mode_r <= `RST_SINGLE_MODE;
		end
		else if (!strap_done_r)
		begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == `STRAP_WAIT_CYC)
			begin
				strap_done_r  <= 1'b1;
				single_mode_r <= c_s & cn_s; // R16 R17
			end
		end
	end

	// ----------------------------------------
	// storage: two arrays, one per burst word
	// ----------------------------------------
	reg [WORD_W-1:0] mem_even [0:DEPTH-1]; // R5
	reg [WORD_W-1:0] mem_odd  [0:DEPTH-1];

	reg              wr_cmd_r;
	reg [ADDR_W-1:0] wr_cmd_addr_r;
	reg              wr_half_r;
	reg [ADDR_W-1:0] wr_addr_r;
	reg [WORD_W-1:0] wr_w0_r;
	reg [1:0]        wr_be0_r;
	reg              post_valid_r;
	reg [ADDR_W-1:0] post_addr_r;
	reg [WORD_W-1:0] post_w0_r;
	reg [WORD_W-1:0] post_w1_r;
	reg [1:0]        post_be0_r;
	reg [1:0]        post_be1_r;

	wire commit = kn_rise & wr_half_r & post_valid_r;

	// old posted burst goes to the array as the next one completes
	always @(posedge clk_sys)
	begin
		if (commit) // R18
		begin
			mem_even[post_addr_r] <= merge_bytes(mem_even[post_addr_r],
			                                     post_w0_r, post_be0_r); // R15 R26 R27
			mem_odd[post_addr_r]  <= merge_bytes(mem_odd[post_addr_r],
			                                     post_w1_r, post_be1_r); // R15 R26 R27
		end
	end

	// ----------------------------------------
	// write path
	// ----------------------------------------

	// command, then word0 on k, word1 on k_n, then posted
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_cmd_r      <= 1'b0;
			wr_cmd_addr_r <= {ADDR_W{1'b0}};
			wr_half_r     <= 1'b0;
			wr_addr_r     <= {ADDR_W{1'b0}};
			wr_w0_r       <= `RST_WORD;
			wr_be0_r      <= 2'h0;
			post_valid_r  <= 1'b0;
			post_addr_r   <= {ADDR_W{1'b0}};
			post_w0_r     <= `RST_WORD;
			post_w1_r     <= `RST_WORD;
			post_be0_r    <= 2'h0;
			post_be1_r    <= 2'h0;
		end
		else
		begin
			if (k_rise) // R1 R3
			begin
				// deselected cycles still latch the address, but set no command
				wr_cmd_r      <= ~load_n_s & ~rw_read_s; // R10 R12 R13 R19
				wr_cmd_addr_r <= addr_s;                 // R10
				wr_half_r     <= wr_cmd_r;               // R11
				if (wr_cmd_r)
				begin
					wr_addr_r <= wr_cmd_addr_r;
					wr_w0_r   <= wdata_s;                // R2 R11
					wr_be0_r  <= ~bws_n_s;               // R14
				end
			end
			else if (kn_rise && wr_half_r)
			begin
				wr_half_r    <= 1'b0;
				post_valid_r <= 1'b1;                    // R18
				post_addr_r  <= wr_addr_r;
				post_w0_r    <= wr_w0_r;
				post_be0_r   <= wr_be0_r;
				post_w1_r    <= wdata_s;                 // R2 R11
				post_be1_r   <= ~bws_n_s;                // R14
			end
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	reg              rd_cmd_r;
	reg [ADDR_W-1:0] rd_cmd_addr_r;
	reg              rd_launch_r;
	reg [WORD_W-1:0] rd_w0_r;
	reg [WORD_W-1:0] rd_w1_r;
	reg              rd_second_r;
	reg [WORD_W-1:0] rd_hold_r;

	wire             post_hit = post_valid_r & (post_addr_r == rd_cmd_addr_r);
	wire [WORD_W-1:0] arr_w0  = mem_even[rd_cmd_addr_r];
	wire [WORD_W-1:0] arr_w1  = mem_odd[rd_cmd_addr_r];

	// fetch one k cycle after the command, posted bytes win
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rd_cmd_r      <= 1'b0;
			rd_cmd_addr_r <= {ADDR_W{1'b0}};
			rd_launch_r   <= 1'b0;
			rd_w0_r       <= `RST_WORD;
			rd_w1_r       <= `RST_WORD;
		end
		else
		begin
			if (k_rise) // R1 R3
			begin
				rd_cmd_r      <= ~load_n_s & rw_read_s; // R6 R8 R19
				rd_cmd_addr_r <= addr_s;                // R6
			end
			if (k_rise && rd_cmd_r)
			begin
				rd_launch_r <= 1'b1;                    // R7
				rd_w0_r     <= post_hit ? merge_bytes(arr_w0, post_w0_r, post_be0_r)
				                        : arr_w0;       // R26 R28
				rd_w1_r     <= post_hit ? merge_bytes(arr_w1, post_w1_r, post_be1_r)
				                        : arr_w1;       // R26 R28
			end
			else if (oneg_rise)
				rd_launch_r <= 1'b0;
		end
	end

	// word1 is parked so a following fetch cannot clobber it
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata       <= `RST_WORD;
			rdata_oe    <= 1'b0;                     // R25
			rd_second_r <= 1'b0;
			rd_hold_r   <= `RST_WORD;
		end
		else if (oneg_rise && rd_launch_r)
		begin
			rdata       <= rd_w0_r;                  // R4 R7
			rdata_oe    <= 1'b1;
			rd_second_r <= 1'b1;
			rd_hold_r   <= rd_w1_r;
		end
		else if (opos_rise)
		begin
			if (rd_second_r)
			begin
				rdata       <= rd_hold_r;            // R7 R8
				rd_second_r <= 1'b0;
			end
			else if (rdata_oe)
			begin
				rdata    <= `RST_WORD;               // R9
				rdata_oe <= 1'b0;                    // R9
			end
		end
	end

	// ----------------------------------------
	// echo clocks
	// ----------------------------------------

	// free running copies of the timing clocks
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			pos_echo_clk <= 1'b0;
			neg_echo_clk <= 1'b0;
		end
		else
		begin
			pos_echo_clk <= single_mode_r ? k_s : c_s;   // R21
			neg_echo_clk <= single_mode_r ? kn_s : cn_s; // R21
		end
	end

	// ----------------------------------------
	// impedance update and dll lock
	// ----------------------------------------
	reg [11:0] imp_cnt_r;
	reg [11:0] lock_cnt_r;
	reg [15:0] gap_cnt_r;

	// one pulse per IMP_CYC input clock cycles
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			imp_cnt_r        <= 12'h000;
			impedance_update <= 1'b0;
		end
		else
		begin
			impedance_update <= 1'b0;
			if (k_rise)
			begin
				if (imp_cnt_r == IMP_CYC - 1) // R20
				begin
					imp_cnt_r        <= 12'h000;
					impedance_update <= 1'b1;
				end
				else
					imp_cnt_r <= imp_cnt_r + 12'h001;
			end
		end
	end

	// a stalled k level counts as a stopped clock
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			gap_cnt_r  <= 16'h0000;
			lock_cnt_r <= 12'h000;
			dll_locked <= 1'b0;
		end
		else if (!dll_dis_n_s)
		begin
			gap_cnt_r  <= 16'h0000;
			lock_cnt_r <= 12'h000;
			dll_locked <= 1'b0;                         // R24
		end
		else
		begin
			if (k_s != clk_d_r[3])
				gap_cnt_r <= 16'h0000;
			else if (gap_cnt_r != 16'hffff)
				gap_cnt_r <= gap_cnt_r + 16'h0001;
			if (gap_cnt_r >= DLL_STOP_CYC)              // R23
			begin
				lock_cnt_r <= 12'h000;
				dll_locked <= 1'b0;
			end
			else if (k_rise && !dll_locked)
			begin
				if (lock_cnt_r == DLL_LOCK_CYC - 1)     // R22
					dll_locked <= 1'b1;
				lock_cnt_r <= lock_cnt_r + 12'h001;
			end
		end
	end

endmodule

// ==== testbench/sram_port_properties.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// port checker
// ----------------------------------------
module sram_port_chk #(
	parameter WORD_W = 18
)(
	input wire              clk_sys,
	input wire              rstn,
	input wire              k_clk,
	input wire              k_n_clk,
	input wire              c_clk,
	input wire              c_n_clk,
	input wire              load_n,
	input wire              rw_read,
	input wire              dll_disable_n,
	input wire [WORD_W-1:0] rdata,
	input wire              rdata_oe,
	input wire              pos_echo_clk,
	input wire              neg_echo_clk,
	input wire              dll_locked,
	input wire              impedance_update
);
	reg       k_d_r;
	reg       c_d_r;
	reg       neg_last_r;
	reg [1:0] rd_hist_r;
	reg [7:0] k_age_r;
	reg [7:0] c_age_r;

	// output timing clocks; both output pins high marks single clock mode
	wire oclk_p = (c_clk && c_n_clk) ? k_clk : c_clk;
	wire oclk_n = (c_clk && c_n_clk) ? k_n_clk : c_n_clk;

	// raw pin edges; ages saturate so a stopped clock never wraps
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			k_d_r      <= 1'b0;
			c_d_r      <= 1'b0;
			neg_last_r <= 1'b0;
			rd_hist_r  <= 2'h0;
			k_age_r    <= 8'hff;
			c_age_r    <= 8'hff;
		end
		else
		begin
			k_d_r   <= k_clk;
			c_d_r   <= oclk_p;
			k_age_r <= (k_clk && !k_d_r) ? 8'h00 : k_age_r + {7'h0, k_age_r != 8'hff};
			c_age_r <= (oclk_p != c_d_r) ? 8'h00 : c_age_r + {7'h0, c_age_r != 8'hff};
			if (k_clk && !k_d_r)
				rd_hist_r <= {rd_hist_r[0], !load_n && rw_read};
			if (oclk_p != c_d_r)
				neg_last_r <= oclk_n;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// start of a read burst and the output edge that times it
	sequence s_oe_rise;
		$rose(rdata_oe);
	endsequence
	sequence s_cn_rise;
		$rose(oclk_n);
	endsequence

	AST_IDLE_ZERO: assert property (!rdata_oe |-> rdata == '0)
		else $error("read data not zero while undriven");
	AST_RD_CAUSE: assert property (s_oe_rise |-> rd_hist_r[1] && k_age_r inside {[21:29]})
		else $error("burst without read command");
	AST_OE_ON_NEG: assert property (s_oe_rise |-> neg_last_r)
		else $error("first word off negative rise");
	AST_OE_OFF_POS: assert property ($fell(rdata_oe) |-> !neg_last_r)
		else $error("release off positive rise");
	AST_LAUNCH_EDGE: assert property ($changed(rdata) |-> c_age_r <= 8'h08)
		else $error("read data moved off an output edge");
	AST_POS_ECHO: assert property ($rose(oclk_p) |-> ##[1:5] pos_echo_clk)
		else $error("positive echo lags");
	AST_NEG_ECHO: assert property (s_cn_rise |-> ##[1:5] neg_echo_clk)
		else $error("negative echo lags");
	AST_IMP_PULSE: assert property (impedance_update |=> !impedance_update [*8])
		else $error("impedance pulse too long");
	AST_DLL_OFF: assert property (!dll_disable_n [*5] |-> !dll_locked)
		else $error("lock shown while disabled");
endmodule

bind ddr_separate_io_burst_sram_port sram_port_chk #(.WORD_W(WORD_W)) u_sram_port_chk (
	.clk_sys(clk_sys), .rstn(rstn), .k_clk(k_clk), .k_n_clk(k_n_clk), .c_clk(c_clk),
	.c_n_clk(c_n_clk), .load_n(load_n), .rw_read(rw_read),
	.dll_disable_n(dll_disable_n), .rdata(rdata),
	.rdata_oe(rdata_oe), .pos_echo_clk(pos_echo_clk), .neg_echo_clk(neg_echo_clk),
	.dll_locked(dll_locked), .impedance_update(impedance_update));

// ==== testbench/mem_ctrl_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// controller clock pairs
// ----------------------------------------
module mem_ctrl_model (
	input  wire clk_sys,
	input  wire rstn,
	input  wire run,
	input  wire single,
	output reg  k_clk,
	output reg  k_n_clk,
	output wire c_clk,
	output wire c_n_clk,
	output reg  mid
);
	reg [4:0] cnt_r;

	// zero skew output pair; single holds both high as the strap
	assign c_clk   = single | k_clk;
	assign c_n_clk = single | k_n_clk;

	// 20 cycles a half gives 160 ns; clocks freeze while run is low
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_r   <= 5'h00;
			k_clk   <= 1'b0;
			k_n_clk <= 1'b1;
			mid     <= 1'b0;
		end
		else if (run)
		begin
			cnt_r <= (cnt_r == 5'h13) ? 5'h00 : cnt_r + 5'h01;
			mid   <= (cnt_r == 5'h09);
			if (cnt_r == 5'h13)
			begin
				k_clk   <= ~k_clk;
				k_n_clk <= k_clk;
			end
		end
		else
			mid <= 1'b0;
	end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// burst port bench
// ----------------------------------------
module tb_top;
	localparam AW = 4;
	reg           clk_sys;
	reg           rstn;
	reg           run;
	reg           single;
	reg           load_n;
	reg           rw_read;
	reg  [1:0]    bws_n;
	reg           dll_disable_n;
	reg  [AW-1:0] addr;
	reg  [17:0]   wdata;
	wire [17:0]   rdata;
	wire          rdata_oe;
	wire          dll_locked;
	wire          imp_upd;
	wire          k_clk;
	wire          k_n_clk;
	wire          c_clk;
	wire          c_n_clk;
	wire          mid;
	int           fail_count;
	int           samples_checked;
	int           imp_cnt;
	int           imp_base;

	mem_ctrl_model u_mem_ctrl_model (.clk_sys(clk_sys), .rstn(rstn), .run(run), .single(single),
		.k_clk(k_clk), .k_n_clk(k_n_clk), .c_clk(c_clk), .c_n_clk(c_n_clk), .mid(mid));

	ddr_separate_io_burst_sram_port #(.ADDR_W(AW), .DLL_LOCK_CYC(8), .IMP_CYC(8),
		.DLL_STOP_CYC(64)) u_ddr_separate_io_burst_sram_port (.clk_sys(clk_sys),
		.rstn(rstn), .k_clk(k_clk), .k_n_clk(k_n_clk), .c_clk(c_clk), .c_n_clk(c_n_clk),
		.load_n(load_n), .rw_read(rw_read), .byte_write_sel_n(bws_n),
		.dll_disable_n(dll_disable_n), .addr(addr), .wdata(wdata), .rdata(rdata),
		.rdata_oe(rdata_oe), .pos_echo_clk(), .neg_echo_clk(), .dll_locked(dll_locked),
		.impedance_update(imp_upd));

	initial
	begin
		clk_sys = 1'b0;
		forever
			#2 clk_sys = ~clk_sys;
	end

	// counts update pulses for the rate check
	always @(posedge clk_sys)
		if (imp_upd === 1'b1)
			imp_cnt++;

	task summarize;
	begin
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask

	task cmp(input [17:0] got, input [17:0] exp);
	begin
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected word at %0t: %h, wanted %h", $time, got, exp);
		end
	end
	endtask

	task cmpf(input got, input exp);
	begin
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected flag at %0t: %h, wanted %h", $time, got, exp);
		end
	end
	endtask

	// one half period; pins move mid half, far from any sampling edge
	task hs(input ld, input rw, input [AW-1:0] a, input [17:0] d, input [1:0] b);
	begin
		@(posedge clk_sys);
		while (mid !== 1'b1)
			@(posedge clk_sys);
		load_n  <= ld;
		rw_read <= rw;
		addr    <= a;
		wdata   <= d;
		bws_n   <= b;
	end
	endtask

	task idle;
		hs(1'b1, 1'b1, 4'h0, 18'h0, 2'h3);
	endtask

	// next hs call lands before a positive input rise
	task align;
	begin
		@(posedge clk_sys);
		while (!(mid === 1'b1 && k_clk === 1'b1))
			@(posedge clk_sys);
	end
	endtask

	task wr(input [AW-1:0] a, input [17:0] d0, input [1:0] b0, input [17:0] d1,
		input [1:0] b1);
	begin
		hs(1'b0, 1'b0, a, 18'h0, 2'h3);
		idle;
		hs(1'b1, 1'b1, a, d0, b0);
		hs(1'b1, 1'b1, a, d1, b1);
	end
	endtask

	task rd(input [AW-1:0] a, input [17:0] e0, input [17:0] e1, input two,
		input [AW-1:0] b, input [17:0] f0, input [17:0] f1);
	begin
		hs(1'b0, 1'b1, a, 18'h0, 2'h3);
		idle;
		hs(~two, 1'b1, b, 18'h0, 2'h3);
		repeat (2) idle;
		cmp(rdata, e0);
		idle;
		cmp(rdata, e1);
		idle;
		if (two)
			cmp(rdata, f0);
		idle;
		if (two)
		begin
			cmp(rdata, f1);
			repeat (2) idle;
		end
		cmpf(rdata_oe, 1'b0);
	end
	endtask

	// hang guard, well past the ~15 us the sequence needs
	initial
	begin
		#40000;
		fail_count++;
		summarize;
	end

	initial
	begin
		rstn = 1'b0;
		run = 1'b0;
		load_n = 1'b1;
		rw_read = 1'b1;
		bws_n = 2'h3;
		dll_disable_n = 1'b1;
		addr = 4'h0;
		wdata = 18'h0;
		fail_count = 0;
		samples_checked = 0;
		single = 1'b0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (10) @(posedge clk_sys);
		cmpf(rdata_oe, 1'b0);
		run <= 1'b1;
		align;
		repeat (24) idle;
		cmpf(dll_locked, 1'b1);
		wr(4'h2, 18'h12345, 2'h0, 18'h2abcd, 2'h0);
		rd(4'h2, 18'h12345, 18'h2abcd, 1'b0, 4'h0, 18'h0, 18'h0);
		// back to back writes: second command shares the first data slot
		hs(1'b0, 1'b0, 4'h3, 18'h0, 2'h3);
		idle;
		hs(1'b0, 1'b0, 4'h4, 18'h3ffff, 2'h0);
		hs(1'b1, 1'b1, 4'h0, 18'h00000, 2'h0);
		hs(1'b1, 1'b1, 4'h0, 18'h15555, 2'h0);
		hs(1'b1, 1'b1, 4'h0, 18'h0aaaa, 2'h0);
		wr(4'h3, 18'h00000, 2'h2, 18'h3ffff, 2'h1);
		wr(4'h4, 18'h11111, 2'h3, 18'h22222, 2'h3);
		wr(4'h5, 18'h00077, 2'h0, 18'h00088, 2'h0);
		rd(4'h3, 18'h3fe00, 18'h3fe00, 1'b1, 4'h4, 18'h15555, 18'h0aaaa);
		rd(4'h5, 18'h00077, 18'h00088, 1'b1, 4'h2, 18'h12345, 18'h2abcd);
		// load low only at the negative rise must start nothing
		idle;
		hs(1'b0, 1'b1, 4'h6, 18'h0, 2'h3);
		repeat (6)
		begin
			idle;
			cmpf(rdata_oe, 1'b0);
		end
		dll_disable_n <= 1'b0;
		repeat (2) idle;
		cmpf(dll_locked, 1'b0);
		dll_disable_n <= 1'b1;
		repeat (24) idle;
		cmpf(dll_locked, 1'b1);
		run <= 1'b0;
		repeat (100) @(posedge clk_sys);
		cmpf(dll_locked, 1'b0);
		run <= 1'b1;
		align;
		repeat (24) idle;
		cmpf(dll_locked, 1'b1);
		imp_base = imp_cnt;
		repeat (32) idle;
		cmp(imp_cnt[17:0] - imp_base[17:0], 18'h2);
		// mid-run reset with both output clock pins high selects single mode
		run    <= 1'b0;
		single <= 1'b1;
		rstn   <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (10) @(posedge clk_sys);
		cmpf(rdata_oe, 1'b0);
		run <= 1'b1;
		align;
		rd(4'h2, 18'h12345, 18'h2abcd, 1'b0, 4'h0, 18'h0, 18'h0);
		summarize;
	end
endmodule
